// [hw/bjie_defs.svh]
/*
 * Constants for the branch, jump and increment execute block: opcodes,
 * addressing limits, counter step and reset values.
 * Assumes inclusion by bare name from any design file that needs them.
 */
`ifndef BJIE_DEFS_SVH
`define BJIE_DEFS_SVH

// ----------------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------------
`define BJIE_OP_BR_CARRY_CLR   8'hE3
`define BJIE_OP_BR_NEG_CLR     8'hE7
`define BJIE_OP_JUMP_WORD1     8'hEF
`define BJIE_OP_JUMP_WORD2     4'hF
`define BJIE_OP_INCR           6'h0A

// ----------------------------------------------------------------------
// addressing and counter
// ----------------------------------------------------------------------
`define BJIE_ILO_MAX_ADDR      8'h5F
`define BJIE_ACCESS_SPLIT      8'h60
`define BJIE_ACCESS_LOW_BANK   4'h0
`define BJIE_ACCESS_HIGH_BANK  4'hF
`define BJIE_PC_STEP           21'h0_0002
`define BJIE_INCR_STEP         9'h001

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define BJIE_PC_RESET          21'h0_0000
`define BJIE_ACC_RESET         8'h00
`define BJIE_IR_RESET          16'h0000

`endif

// [hw/bjie_pkg.sv]
/*
 * Types for the branch, jump and increment execute block: quadrature
 * phase, sequencing state and the packed state record of the top module.
 * Assumes nothing of its surroundings.
 */
package bjie_pkg;

    // ------------------------------------------------------------------
    // quadrature phases, gray coded
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        BJIE_Q1 = 2'b00,
        BJIE_Q2 = 2'b01,
        BJIE_Q3 = 2'b11,
        BJIE_Q4 = 2'b10
    } bjie_phase_t;

    // ------------------------------------------------------------------
    // instruction cycle kind, gray coded along exec->second cycle
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        BJIE_EXEC  = 2'b00,
        BJIE_JUMP2 = 2'b01,
        BJIE_FLUSH = 2'b10
    } bjie_state_t;

    // ------------------------------------------------------------------
    // whole state of the execute block
    // ------------------------------------------------------------------
    typedef struct packed {
        bjie_phase_t phase;
        bjie_state_t st;
        logic        active;
        logic [15:0] ir;
        logic [20:0] pc;
        logic [7:0]  jump_low;
        logic [7:0]  acc;
        logic        c;
        logic        dc;
        logic        z;
        logic        ov;
        logic        n;
        logic [11:0] rd_addr;
        logic [7:0]  operand;
        logic [7:0]  result;
        logic [4:0]  new_flags;
        logic        unknown;
    } bjie_state_rec_t;

endpackage : bjie_pkg

// [hw/bjie_branch_target.sv]
/*
 * Relative branch target: counter plus step plus doubled signed offset.
 * Assumes a pure combinational use by the execute block.
 */
`timescale 1ns/10ps
`include "bjie_defs.svh"

module bjie_branch_target (
    input  wire logic [20:0] pc,
    input  wire logic [7:0]  offset,
    output logic      [20:0] target
);

    // ------------------------------------------------------------------
    // sign extend, double, add
    // ------------------------------------------------------------------
    logic [20:0] offset_x2;

    // offset is two's complement, -128..127 words
    assign offset_x2 = {{12{offset[7]}}, offset, 1'b0};
    // wraps inside the 21-bit space, as the counter does
    assign target = pc + `BJIE_PC_STEP + offset_x2;

endmodule : bjie_branch_target

// [hw/bjie_incr_alu.sv]
/*
 * Byte incrementer with status flag outputs.
 * Assumes a pure combinational use by the execute block.
 */
`timescale 1ns/10ps
`include "bjie_defs.svh"

module bjie_incr_alu (
    input  wire logic [7:0] operand,
    output logic      [7:0] result,
    output logic            carry,
    output logic            digit_carry_flag,
    output logic            arith_wrap_flag,
    output logic            negative,
    output logic            zero
);

    // ------------------------------------------------------------------
    // add one and derive flags
    // ------------------------------------------------------------------
    logic [8:0] sum;

    assign sum              = {1'b0, operand} + `BJIE_INCR_STEP;
    assign result           = sum[7:0];
    assign carry            = sum[8];
    assign digit_carry_flag = (operand[3:0] == 4'hF);
    assign arith_wrap_flag  = ~operand[7] & sum[7];
    assign negative         = sum[7];
    assign zero             = (sum[7:0] == 8'h00);

endmodule : bjie_incr_alu

// [hw/bjie_exec.sv]
/*
 * Execute block for carry-clear branch, negative-clear branch,
 * two-word absolute jump and file register increment. Each
 * instruction cycle is four ref_clk cycles, phases Q1..Q4.
 * Assumes the fetch unit presents the word at address pc during Q1
 * with instr_valid, and a register file that returns rf_rd_data in the
 * same cycle as rf_rd_en and stores rf_wr_data on rf_wr_en.
 * Limits: no skip or interrupt logic; a
 * missing word repeats the cycle, counter
 * held; a jump whose second word never
 * comes stalls until it does.
 */
// Notes on behaviour
// - carry clear: counter gets pc+2+2n
// - carry-clear branch opcode byte E3h
// - negative clear: counter gets pc+2+2n
// - negative-clear branch opcode byte E7h
// - taken branch: two cycles, second idle
// - untaken branch: one cycle, no Q4 write
// - jump: EFh word then Fh word
// - jump target loads counter bits 20:1
// - increment reads file, adds one, writes
// - destination zero writes accumulator only
// - destination one writes file register back
// - bank bit zero uses fixed access window
// - bank bit one uses bank select
// - extended set, low bank, f<=5Fh: indexed
// - increment updates C, DC, N, OV, Z
// - increment opcode top six bits 001010
`timescale 1ns/10ps
`include "bjie_defs.svh"

module bjie_exec (
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    // fetch side
    input  wire logic        instr_valid,
    input  wire logic [15:0] instr_word,
    output logic             instr_ready,
    output logic      [20:0] pc,

    // addressing context
    input  wire logic        ext_set_en,
    input  wire logic [3:0]  bank_select_reg,
    input  wire logic [11:0] ilo_base,

    // register file side
    output logic             rf_rd_en,
    output logic      [11:0] rf_rd_addr,
    input  wire logic [7:0]  rf_rd_data,
    output logic             rf_wr_en,
    output logic      [11:0] rf_wr_addr,
    output logic      [7:0]  rf_wr_data,

    // core state
    output logic      [7:0]  acc,
    output logic      [1:0]  q_phase,
    output logic             carry,
    output logic             digit_carry_flag,
    output logic             zero,
    output logic             arith_wrap_flag,
    output logic             negative,
    output logic             pc_write,
    output logic             instr_unknown
);

    // ------------------------------------------------------------------
    // state record
    // ------------------------------------------------------------------
    bjie_pkg::bjie_state_rec_t r;
    bjie_pkg::bjie_state_rec_t next_r;

    // ------------------------------------------------------------------
    // decode of the latched word
    // ------------------------------------------------------------------
    logic        is_br_carry;
    logic        is_br_neg;
    logic        is_jump1;
    logic        is_incr;

    logic        incr_dest;
    logic        br_taken;
    logic [20:0] br_target;

    logic [7:0]  alu_result;
    logic        alu_c;
    logic        alu_dc;
    logic        alu_ov;
    logic        alu_n;
    logic        alu_z;

    logic [11:0] fetch_addr;

    // gated by active: an idle or flushed
    // cycle must not match a stale opcode

    // opcode recognition on the instruction register
    assign is_br_carry = r.active & (r.ir[15:8] == `BJIE_OP_BR_CARRY_CLR);
    assign is_br_neg   = r.active & (r.ir[15:8] == `BJIE_OP_BR_NEG_CLR);
    assign is_jump1    = r.active & (r.ir[15:8] == `BJIE_OP_JUMP_WORD1);
    assign is_incr     = r.active & (r.ir[15:10] == `BJIE_OP_INCR);

    assign incr_dest   = r.ir[9];

    // flags move only at the Q4 commit, so
    // a branch sees the prior instruction's

    // branch condition against the flags as they stand at Q4
    assign br_taken = (is_br_carry & ~r.c)
                    | (is_br_neg & ~r.n);

    // wraps in 21 bits like the counter
    bjie_branch_target u_target (
        .pc     (r.pc),
        .offset (r.ir[7:0]),
        .target (br_target)
    );

    // operand was taken from the file in Q2
    bjie_incr_alu u_alu (
        .operand          (r.operand),
        .result           (alu_result),
        .carry            (alu_c),
        .digit_carry_flag (alu_dc),
        .arith_wrap_flag  (alu_ov),
        .negative         (alu_n),
        .zero             (alu_z)
    );

    // ------------------------------------------------------------------
    // file address resolution, done on the incoming word at Q1
    // ------------------------------------------------------------------
    // indexed mode wins over the access window when it applies
    // latched at Q1: a later bank change
    // cannot move this access
    always_comb begin
        if (!instr_word[8] && ext_set_en
            && (instr_word[7:0] <= `BJIE_ILO_MAX_ADDR)) begin
            fetch_addr = ilo_base + {4'h0, instr_word[7:0]};
        end else if (!instr_word[8]) begin
            if (instr_word[7:0] < `BJIE_ACCESS_SPLIT) begin
                fetch_addr = {`BJIE_ACCESS_LOW_BANK, instr_word[7:0]};
            end else begin
                fetch_addr = {`BJIE_ACCESS_HIGH_BANK, instr_word[7:0]};
            end
        end else begin
            fetch_addr = {bank_select_reg, instr_word[7:0]};
        end
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_r         = r;
        next_r.unknown = 1'b0;
        // one cycle pulse, set at Q4 only
        unique case (r.phase)
            bjie_pkg::BJIE_Q1: begin
                next_r.phase = bjie_pkg::BJIE_Q2;
                // word and address taken together
                if (r.st == bjie_pkg::BJIE_EXEC) begin
                    // a missing word makes this cycle idle, counter held
                    next_r.active  = instr_valid;
                    next_r.ir      = instr_word;
                    next_r.rd_addr = fetch_addr;
                end else if (r.st == bjie_pkg::BJIE_JUMP2) begin
                    // second word only carries target bits 19:8
                    next_r.active = instr_valid;
                    next_r.ir     = instr_word;
                end else begin
                    next_r.active = 1'b0;   // idle cycle after a taken branch
                end
            end

            bjie_pkg::BJIE_Q2: begin
                next_r.phase = bjie_pkg::BJIE_Q3;
                // register file answers in the read cycle
                if (is_incr && r.st == bjie_pkg::BJIE_EXEC) begin
                    next_r.operand = rf_rd_data;
                end
            end

            bjie_pkg::BJIE_Q3: begin
                next_r.phase = bjie_pkg::BJIE_Q4;
                // held in the record until Q4
                if (is_incr && r.st == bjie_pkg::BJIE_EXEC) begin
                    next_r.result    = alu_result;
                    next_r.new_flags = {alu_c, alu_dc, alu_z, alu_ov, alu_n};
                end
            end

            bjie_pkg::BJIE_Q4: begin
                next_r.phase = bjie_pkg::BJIE_Q1;
                unique case (r.st)
                    bjie_pkg::BJIE_EXEC: begin
                        if (!r.active) begin
                            next_r.pc = r.pc;   // nothing fetched, retry
                        end else if (br_taken) begin
                            next_r.pc = br_target;
                            next_r.st = bjie_pkg::BJIE_FLUSH;
                        end else if (is_jump1) begin
                            // word two comes at pc + 2
                            next_r.jump_low = r.ir[7:0];
                            next_r.pc       = r.pc + `BJIE_PC_STEP;
                            next_r.st       = bjie_pkg::BJIE_JUMP2;
                        end else begin
                            // untaken branch just steps on
                            next_r.pc = r.pc + `BJIE_PC_STEP;
                            if (is_incr) begin
                                {next_r.c, next_r.dc, next_r.z, next_r.ov, next_r.n} =
                                    r.new_flags;
                                if (!incr_dest) begin
                                    next_r.acc = r.result;
                                end
                            end else if (!is_br_carry && !is_br_neg) begin
                                next_r.unknown = 1'b1;
                            end
                        end
                    end

                    bjie_pkg::BJIE_JUMP2: begin
                        // second word missing: wait for it, counter held
                        if (r.active
                            && r.ir[15:12] == `BJIE_OP_JUMP_WORD2) begin
                            next_r.pc = {r.ir[11:0], r.jump_low, 1'b0};
                            next_r.st = bjie_pkg::BJIE_EXEC;
                        end else if (r.active) begin
                            // malformed second word: abandon the jump
                            next_r.pc      = r.pc + `BJIE_PC_STEP;
                            next_r.st      = bjie_pkg::BJIE_EXEC;
                            next_r.unknown = 1'b1;
                        end
                    end

                    bjie_pkg::BJIE_FLUSH: begin
                        // idle cycle writes nothing
                        next_r.st = bjie_pkg::BJIE_EXEC;
                    end

                    default: begin
                        next_r.st = bjie_pkg::BJIE_EXEC;
                    end
                endcase
            end
        endcase
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    // sync reset to constants only
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            r.phase     <= bjie_pkg::BJIE_Q1;
            r.st        <= bjie_pkg::BJIE_EXEC;
            r.active    <= 1'b0;
            r.ir        <= `BJIE_IR_RESET;
            r.pc        <= `BJIE_PC_RESET;
            r.jump_low  <= 8'h00;
            r.acc       <= `BJIE_ACC_RESET;
            r.c         <= 1'b0;
            r.dc        <= 1'b0;
            r.z         <= 1'b0;
            r.ov        <= 1'b0;
            r.n         <= 1'b0;
            r.rd_addr   <= 12'h000;
            r.operand   <= 8'h00;
            r.result    <= 8'h00;
            r.new_flags <= 5'h00;
            r.unknown   <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // fetch word taken at Q1 of every non-idle cycle
    assign instr_ready = (r.phase == bjie_pkg::BJIE_Q1)
                       & (r.st != bjie_pkg::BJIE_FLUSH);
    assign pc          = r.pc;
    assign q_phase     = r.phase;


    // combinational: they drop with the phase
    // read in Q2, write in Q4 only when destination is the file
    assign rf_rd_en   = (r.phase == bjie_pkg::BJIE_Q2) & is_incr
                      & (r.st == bjie_pkg::BJIE_EXEC);
    assign rf_rd_addr = r.rd_addr;
    assign rf_wr_en   = (r.phase == bjie_pkg::BJIE_Q4) & is_incr & incr_dest
                      & (r.st == bjie_pkg::BJIE_EXEC);
    assign rf_wr_addr = r.rd_addr;
    assign rf_wr_data = r.result;

    // counter write strobe marks Q4 of a taken branch or jump second word
    // the only cycles where the counter jumps
    assign pc_write = (r.phase == bjie_pkg::BJIE_Q4)
                    & (((r.st == bjie_pkg::BJIE_EXEC) & br_taken)
                    | ((r.st == bjie_pkg::BJIE_JUMP2) & r.active
                    & (r.ir[15:12] == `BJIE_OP_JUMP_WORD2)));


    // core state straight from the record
    assign acc              = r.acc;
    assign carry            = r.c;
    assign digit_carry_flag = r.dc;
    assign zero             = r.z;
    assign arith_wrap_flag  = r.ov;
    assign negative         = r.n;
    assign instr_unknown    = r.unknown;

endmodule : bjie_exec

// [tb/bjie_exec_props.sv]
/*
 * Checker for bjie_exec: phase order, branch and jump timing, increment
 * read/write sequence and addressing.
 * Assumes a bind to bjie_exec and a fetch side that holds its word in Q1.
 */
`timescale 1ns/10ps

module bjie_exec_props (
    input wire logic        ref_clk,
    input wire logic        rst_b,
    input wire logic        instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic        instr_ready,
    input wire logic [20:0] pc,
    input wire logic [3:0]  bank_select_reg,
    input wire logic        rf_rd_en,
    input wire logic [11:0] rf_rd_addr,
    input wire logic [7:0]  rf_rd_data,
    input wire logic        rf_wr_en,
    input wire logic [7:0]  rf_wr_data,
    input wire logic [1:0]  q_phase,
    input wire logic        carry,
    input wire logic        negative,
    input wire logic        pc_write
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    // ------------------------------------------------------------------
    // helper decode of the word taken in Q1
    // ------------------------------------------------------------------
    logic        take;
    logic        is_incr;
    logic        br_take;
    logic        br_skip;
    logic [1:0]  ph_nxt;
    logic [7:0]  w_low;
    logic [11:0] w_top;
    logic        w_dst;
    logic [20:0] br_step;

    // offset doubled after sign extension, as the counter sees it
    always_comb begin
        take    = instr_ready && instr_valid && q_phase == 2'b00;
        is_incr = take && instr_word[15:10] == 6'h0A;
        br_take = take && ((instr_word[15:8] == 8'hE3 && !carry) ||
                           (instr_word[15:8] == 8'hE7 && !negative));
        br_skip = take && ((instr_word[15:8] == 8'hE3 && carry) ||
                           (instr_word[15:8] == 8'hE7 && negative));
        w_low   = instr_word[7:0];
        w_top   = instr_word[11:0];
        w_dst   = instr_word[9];
        br_step = {{12{instr_word[7]}}, instr_word[7:0], 1'b0};
        case (q_phase)
            2'b00:   ph_nxt = 2'b01;
            2'b01:   ph_nxt = 2'b11;
            2'b11:   ph_nxt = 2'b10;
            default: ph_nxt = 2'b00;
        endcase
    end

    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    phase_order_a: assert property ($past(rst_b) |-> q_phase == $past(ph_nxt))
        else $error("quadrature phase out of order");
    ready_in_q1_a: assert property (instr_ready |-> q_phase == 2'b00)
        else $error("fetch ready outside Q1");
    pc_load_q4_a: assert property (pc_write |-> q_phase == 2'b10)
        else $error("counter load outside Q4");
    branch_target_a: assert property (br_take |-> ##3 pc_write
        ##1 pc == $past(pc, 4) + 21'h0_0002 + $past(br_step, 4))
        else $error("taken branch target wrong");
    branch_idle_a: assert property (br_take |-> ##4 (!instr_ready) [*4])
        else $error("taken branch second cycle not idle");
    branch_skip_a: assert property (br_skip |-> ##3 !pc_write
        ##1 pc == $past(pc, 4) + 21'h0_0002)
        else $error("untaken branch moved counter");
    incr_seq_a: assert property (is_incr |=> rf_rd_en
        ##2 rf_wr_en == $past(w_dst, 3))
        else $error("increment read or write slot wrong");
    incr_data_a: assert property (rf_wr_en |-> rf_wr_data == $past(rf_rd_data, 2) + 8'h01)
        else $error("increment write data wrong");
    bank_addr_a: assert property (is_incr && instr_word[8] |=>
        rf_rd_addr == {$past(bank_select_reg), $past(w_low)})
        else $error("banked address wrong");
    jump_target_a: assert property (take && instr_word[15:8] == 8'hEF
        ##4 (take && instr_word[15:12] == 4'hF) |->
        ##4 pc == {$past(w_top, 4), $past(w_low, 8), 1'b0})
        else $error("jump target wrong");
endmodule : bjie_exec_props

bind bjie_exec bjie_exec_props bjie_exec_props_inst (.ref_clk, .rst_b, .instr_valid,
    .instr_word, .instr_ready, .pc, .bank_select_reg, .rf_rd_en, .rf_rd_addr,
    .rf_rd_data, .rf_wr_en, .rf_wr_data, .q_phase, .carry, .negative, .pc_write);

// [tb/bjie_partner.sv]
/*
 * Fetch unit and data register file model facing bjie_exec.
 * Assumes the bench loads prog and rf by hierarchical reference.
 */
`timescale 1ns/10ps

module bjie_partner (
    input  wire logic        ref_clk,
    input  wire logic [20:0] pc,
    output logic             instr_valid,
    output logic      [15:0] instr_word,
    input  wire logic        rf_rd_en,
    input  wire logic [11:0] rf_rd_addr,
    output logic      [7:0]  rf_rd_data,
    input  wire logic        rf_wr_en,
    input  wire logic [11:0] rf_wr_addr,
    input  wire logic [7:0]  rf_wr_data
);
    logic [16:0] prog [64];
    logic [7:0]  rf [4096];
    logic [7:0]  last_rd = 8'h5A;
    logic [16:0] entry;

    // fetch: bit 16 marks a loaded word; gaps show a flipped pattern
    assign entry       = prog[pc[6:1]];
    assign instr_valid = entry[16];
    assign instr_word  = entry[16] ? entry[15:0] : ~entry[15:0];

    // read answers in the same cycle; undriven bus shows inverted last value
    assign rf_rd_data = rf_rd_en ? rf[rf_rd_addr] : ~last_rd;

    // file storage, written on the write strobe
    always @(posedge ref_clk) begin
        if (rf_rd_en) last_rd <= rf[rf_rd_addr];
        if (rf_wr_en) rf[rf_wr_addr] <= rf_wr_data;
    end
endmodule : bjie_partner

// [tb/bjie_exec_test.sv]
/*
 * Self-checking bench for bjie_exec: branches, jump, increment.
 * Assumes bjie_partner as fetch unit and register file.
 */
`timescale 1ns/10ps

module bjie_exec_test;
    logic        ref_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        instr_valid, instr_ready, pc_write, instr_unknown, ext_set_en;
    logic        rf_rd_en, rf_wr_en, carry, digit_carry_flag, zero;
    logic        arith_wrap_flag, negative;
    logic [15:0] instr_word;
    logic [20:0] pc, exp_pc;
    logic [3:0]  bank_select_reg;
    logic [11:0] ilo_base, rf_rd_addr, rf_wr_addr;
    logic [7:0]  rf_rd_data, rf_wr_data, acc, exp_acc;
    logic [1:0]  q_phase;
    int          error_cnt, checked;

    bjie_exec bjie_exec_inst (.ref_clk, .rst_b, .instr_valid, .instr_word, .instr_ready,
        .pc, .ext_set_en, .bank_select_reg, .ilo_base, .rf_rd_en, .rf_rd_addr,
        .rf_rd_data, .rf_wr_en, .rf_wr_addr, .rf_wr_data, .acc, .q_phase, .carry,
        .digit_carry_flag, .zero, .arith_wrap_flag, .negative, .pc_write, .instr_unknown);
    bjie_partner bjie_partner_inst (.ref_clk, .pc, .instr_valid, .instr_word, .rf_rd_en,
        .rf_rd_addr, .rf_rd_data, .rf_wr_en, .rf_wr_addr, .rf_wr_data);

    // 250 MHz clock
    always #2 ref_clk = ~ref_clk;

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // load word(s) at the expected counter, wait whole instruction cycles
    task automatic run(input logic [15:0] w1, input logic [15:0] w2, input int ncyc);
        int n;
        n = 0;
        while (q_phase !== 2'b00 && n < 8) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        bjie_partner_inst.prog[exp_pc[6:1]] = {1'b1, w1};
        bjie_partner_inst.prog[exp_pc[6:1] + 6'h01] = {w1[15:8] == 8'hEF, w2};
        repeat (4 * ncyc) @(posedge ref_clk);
        #1;
        // drop the words so nothing runs twice after a counter wrap
        for (int i = 0; i < 64; i++) bjie_partner_inst.prog[i] = 17'h0_0000;
    endtask : run

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic branch(input logic [7:0] op, input logic [7:0] off, input logic taken);
        logic [20:0] tgt;
        tgt = exp_pc + 21'h0_0002 + (taken ? {{12{off[7]}}, off, 1'b0} : 21'h0_0000);
        run({op, off}, 16'h0000, taken ? 2 : 1);
        exp_pc = tgt;
        check("branch pc", pc, exp_pc);
    endtask : branch

    task automatic incr(input logic d, input logic a, input logic [7:0] f,
                        input logic [11:0] addr, input logic [7:0] v);
        logic [7:0] r;
        r = v + 8'h01;
        bjie_partner_inst.rf[addr] = v;
        run({6'h0A, d, a, f}, 16'h0000, 1);
        exp_pc = exp_pc + 21'h0_0002;
        if (!d) exp_acc = r;
        check("file reg", bjie_partner_inst.rf[addr], d ? r : v);
        check("acc", acc, exp_acc);
        check("flags", {carry, digit_carry_flag, negative, arith_wrap_flag, zero},
              {v == 8'hFF, v[3:0] == 4'hF, r[7], v == 8'h7F, r == 8'h00});
        check("incr pc", pc, exp_pc);
    endtask : incr

    task automatic jump_far(input logic [19:0] k);
        run({8'hEF, k[7:0]}, {4'hF, k[19:8]}, 2);
        exp_pc = {k, 1'b0};
        check("jump pc", pc, exp_pc);
    endtask : jump_far

    // undecoded word, then an empty fetch slot that must hold the counter
    task automatic odd_word();
        run(16'h0000, 16'h0000, 1);
        exp_pc = exp_pc + 21'h0_0002;
        check("unknown", instr_unknown, 1'b1);
        repeat (4) @(posedge ref_clk);
        #1;
        check("idle pc", pc, exp_pc);
    endtask : odd_word

    task automatic print_verdict();
        $display("counts: checked %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        error_cnt = 0;
        checked = 0;
        exp_pc = 21'h0_0000;
        exp_acc = 8'h00;
        ext_set_en = 1'b0;
        bank_select_reg = 4'h5;
        ilo_base = 12'h300;
        for (int i = 0; i < 4096; i++) bjie_partner_inst.rf[i] = 8'h00;
        for (int i = 0; i < 64; i++) bjie_partner_inst.prog[i] = 17'h0_0000;
        repeat (16) @(posedge ref_clk);
        #1 rst_b = 1'b1;
        incr(1'b1, 1'b0, 8'h20, 12'h020, 8'hFF);
        branch(8'hE3, 8'h10, 1'b0);
        branch(8'hE7, 8'h80, 1'b1);
        incr(1'b0, 1'b1, 8'h33, 12'h533, 8'h7F);
        branch(8'hE3, 8'h7F, 1'b1);
        branch(8'hE7, 8'h05, 1'b0);
        ext_set_en = 1'b1;
        incr(1'b1, 1'b0, 8'h5F, 12'h35F, 8'h0F);
        incr(1'b1, 1'b0, 8'h60, 12'hF60, 8'h10);
        jump_far(20'hA_BCDE);
        odd_word();
        print_verdict();
    end

    // hang guard, well beyond the under one hundred cycles the run needs
    initial begin
        repeat (3000) @(posedge ref_clk);
        error_cnt++;
        print_verdict();
    end
endmodule : bjie_exec_test
